/* File: psd_pkg.sv */
// shared constants, field layouts and types for the synthesizer core
package psd_pkg;
    // serial frame layout: last bit shifted is the divider select bit
    localparam int SR_W = 19;
    localparam int A_W = 7;
    localparam int N_W = 11;
    localparam int R_W = 12;
    localparam int SEL_BIT = 0;
    localparam int A_LSB = 1;
    localparam int N_LSB = 8;
    localparam int R_LSB = 1;
    localparam logic SEL_VCO = 1'b0;
    localparam logic SEL_REF = 1'b1;

    // ratios after reset, before software loads real values
    localparam logic [N_W-1:0] RST_MAIN = 11'h005;
    localparam logic [A_W-1:0] RST_SWALLOW = 7'h00;
    localparam logic [R_W-1:0] RST_REF = 12'h005;
    localparam logic [N_W-1:0] MAIN_LAST = 11'h001;
    localparam logic [A_W-1:0] SWALLOW_ONE = 7'h01;
    localparam logic [A_W-1:0] SWALLOW_NONE = 7'h00;
    localparam logic [R_W-1:0] REF_ONE = 12'h001;
    localparam logic [R_W-1:0] REF_ZERO = 12'h000;

    // lock detector: zero-error comparisons needed before lock
    localparam logic [2:0] LOCK_COUNT = 3'h4;
    localparam logic [2:0] ZERO_ONE = 3'h1;

    // prescaler modulus levels
    localparam logic MOD_SMALL = 1'b1;
    localparam logic MOD_LARGE = 1'b0;

    // register bus map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_VCO_RATIO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_REF_RATIO = 8'h0c;
    localparam int CTRL_STANDBY_BIT = 0;
    localparam logic RST_CTRL_STANDBY = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // number of pin inputs passed through synchronisers
    localparam int PIN_N = 8;

    typedef struct packed {
        logic [N_W-1:0] main;
        logic [A_W-1:0] swallow;
    } psd_vco_ratio_t;

    typedef struct packed {
        logic serial_clk;
        logic serial_data;
        logic latch_strobe;
        logic vco_fb;
        logic ref_osc;
        logic power_save;
        logic polarity_select;
        logic test_mode;
    } psd_pins_t;

    typedef struct packed {
        logic lock;
        logic active;
        logic modulus;
        logic cp_busy;
    } psd_status_t;

    // phase detector states, one bit change away from idle
    typedef enum logic [1:0] {
        PD_IDLE = 2'b00,
        PD_REF_LEAD = 2'b01,
        PD_VCO_LEAD = 2'b10
    } psd_pd_state_t;
endpackage

/* File: psd_core.sv */
// digital core of the serially programmed pll synthesizer with register bus
// Operation
// R1: shift serial data on serial clock rise
// R2: latch strobe high loads shift register contents
// R3: power save high runs, low stands by
// R4: standby: charge pump off, lock forced high
// R5: wake-up aligns divided reference and vco phases
// R6: controller holds standby during power-up
// R7: modulus output changes on vco falling edges
// R8: 7-bit swallow, 11-bit main counter
// R9: large modulus for swallow count, then small
// R10: controller keeps main count above swallow
// R11: 12-bit reference divider, output equals input/ratio
// R12: polarity select sets pump drive sense
// R13: pump pulse lasts exactly the phase difference
// R14: lock after four zero-error comparisons
// R15: lock drops at once on error
// R16: test input selects test mode, defaults off
// R17: divided reference edges clock lock detector
// R18: final bit selects vco or reference frame
// R19: strobe loads only the selected divider
// R20: extra bits: only newest bits count
// R21: monitors carry dividers only in power/test
`timescale 1ns/1ps
module psd_core
    import psd_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial loader link
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_strobe,
    // loop pins
    input wire logic vco_fb,
    input wire logic ref_osc,
    input wire logic power_save,
    input wire logic polarity_select,
    input wire logic test_mode,
    output logic cp_drive,
    output logic cp_drive_oe,
    output logic modulus_ctrl,
    output logic lock_indicator,
    output logic ref_monitor,
    output logic vco_monitor
);

    // word address match, shared by read and write decode
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction

    psd_pins_t pins_raw;
    psd_pins_t pins_s1_q;
    psd_pins_t pins_s2_q;
    psd_pins_t pins_s3_q;
    logic [SR_W-1:0] sr_q;
    psd_vco_ratio_t vco_ratio_q;
    logic [R_W-1:0] ref_ratio_q;
    logic [R_W-1:0] ref_cnt_q;
    logic [N_W-1:0] main_cnt_q;
    logic [A_W-1:0] swallow_cnt_q;
    logic [A_W-1:0] swallow_next;
    logic modulus_q;
    psd_pd_state_t pd_q;
    psd_pd_state_t pd_d;
    logic cp_drive_q;
    logic cp_oe_q;
    logic [2:0] zero_cnt_q;
    logic [2:0] zero_cnt_d;
    logic err_seen_q;
    logic lock_q;
    logic lock_d;
    logic ref_mon_q;
    logic vco_mon_q;
    logic ctrl_standby_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_data_d;
    logic [1:0] rd_resp_d;
    psd_status_t status;

    // pins gathered so one generate loop synchronises them all
    assign pins_raw = '{serial_clk: serial_clk, serial_data: serial_data, latch_strobe: latch_strobe,
                        vco_fb: vco_fb, ref_osc: ref_osc, power_save: power_save,
                        polarity_select: polarity_select, test_mode: test_mode};

    // two-stage synchronisers; the third stage only feeds edge detection
    for (genvar i = 0; i < PIN_N; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pins_s1_q[i] <= 1'b0;
                pins_s2_q[i] <= 1'b0;
                pins_s3_q[i] <= 1'b0;
            end else begin
                pins_s1_q[i] <= pins_raw[i];
                pins_s2_q[i] <= pins_s1_q[i];
                pins_s3_q[i] <= pins_s2_q[i];
            end
        end
    end

    // edge events and operating mode
    wire sclk_rise = pins_s2_q.serial_clk & ~pins_s3_q.serial_clk;
    wire vco_fall = ~pins_s2_q.vco_fb & pins_s3_q.vco_fb;
    wire ref_rise = pins_s2_q.ref_osc & ~pins_s3_q.ref_osc;
    // standby while power save is low or software forces it; power-up relies on the pin low
    wire active = pins_s2_q.power_save & ~ctrl_standby_q; // R3 R6
    wire strobe_on = pins_s2_q.latch_strobe;
    wire frame_sel = sr_q[SEL_BIT]; // R18

    // serial shift register; older bits fall off the top so the newest win
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_q <= '0;
        end else if (sclk_rise) begin
            sr_q <= {sr_q[SR_W-2:0], pins_s2_q.serial_data}; // R1 R20
        end
    end

    // ratio latches are transparent while the strobe is high, only the selected one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vco_ratio_q <= '{main: RST_MAIN, swallow: RST_SWALLOW};
            ref_ratio_q <= RST_REF;
        end else if (strobe_on) begin
            if (frame_sel == SEL_VCO) begin
                vco_ratio_q <= psd_vco_ratio_t'(sr_q[SR_W-1:A_LSB]); // R2 R19 R8
            end else begin
                ref_ratio_q <= sr_q[R_LSB+R_W-1:R_LSB]; // R2 R19 R11
            end
        end
    end

    // reference divider; held at zero in standby so both dividers restart together
    wire ref_ev = active & ref_rise & (ref_cnt_q == ref_ratio_q - REF_ONE); // R11
    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            ref_cnt_q <= REF_ZERO; // R5
        end else if (ref_ev) begin
            ref_cnt_q <= REF_ZERO;
        end else if (ref_rise) begin
            ref_cnt_q <= ref_cnt_q + REF_ONE;
        end
    end

    // pulse swallow divider: large modulus while swallow count remains
    wire vco_ev = active & vco_fall & (main_cnt_q == MAIN_LAST);
    assign swallow_next = vco_ev ? vco_ratio_q.swallow :
                          (swallow_cnt_q == SWALLOW_NONE) ? SWALLOW_NONE : swallow_cnt_q - SWALLOW_ONE;
    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            main_cnt_q <= vco_ratio_q.main; // R5
            swallow_cnt_q <= vco_ratio_q.swallow;
            modulus_q <= (vco_ratio_q.swallow == SWALLOW_NONE) ? MOD_SMALL : MOD_LARGE;
        end else if (vco_fall) begin
            main_cnt_q <= vco_ev ? vco_ratio_q.main : main_cnt_q - MAIN_LAST; // R8
            swallow_cnt_q <= swallow_next;
            modulus_q <= (swallow_next == SWALLOW_NONE) ? MOD_SMALL : MOD_LARGE; // R7 R9
        end
    end

    // phase-frequency detector; simultaneous edges mean zero error.
    // main count not above swallow count is the controller's fault and is not trapped here
    always_comb begin
        pd_d = pd_q; // R10
        if (!active) begin
            pd_d = PD_IDLE; // R4
        end else begin
            case (pd_q)
                PD_IDLE: begin
                    if (ref_ev && !vco_ev) begin
                        pd_d = PD_REF_LEAD;
                    end else if (vco_ev && !ref_ev) begin
                        pd_d = PD_VCO_LEAD;
                    end
                end
                PD_REF_LEAD: begin
                    if (vco_ev) begin
                        pd_d = PD_IDLE; // R13
                    end
                end
                PD_VCO_LEAD: begin
                    if (ref_ev) begin
                        pd_d = PD_IDLE; // R13
                    end
                end
                default: pd_d = PD_IDLE;
            endcase
        end
    end

    // lock detector counts on divided reference edges; drops without waiting
    wire zero_err = ~err_seen_q & (pd_q == PD_IDLE) & (pd_d == PD_IDLE);
    assign zero_cnt_d = !ref_ev ? zero_cnt_q :
                        !zero_err ? 3'(0) :
                        (zero_cnt_q == LOCK_COUNT) ? LOCK_COUNT : zero_cnt_q + ZERO_ONE; // R17
    assign lock_d = !active ? 1'b1 : // R4
                    (pd_d != PD_IDLE) ? 1'b0 : // R15
                    (zero_cnt_d == LOCK_COUNT); // R14

    // detector state, pump drive and lock flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pd_q <= PD_IDLE;
            cp_drive_q <= 1'b0;
            cp_oe_q <= 1'b0;
            zero_cnt_q <= 3'(0);
            err_seen_q <= 1'b0;
            lock_q <= 1'b1;
        end else begin
            pd_q <= pd_d;
            cp_oe_q <= (pd_d != PD_IDLE); // R4 R13
            cp_drive_q <= (pd_d == PD_REF_LEAD) ? pins_s2_q.polarity_select : ~pins_s2_q.polarity_select; // R12
            zero_cnt_q <= zero_cnt_d;
            err_seen_q <= ref_ev ? 1'b0 : (err_seen_q | (pd_q != PD_IDLE));
            lock_q <= lock_d;
        end
    end

    // monitor outputs; the test pad's pull-down keeps this off when floating
    wire monitor_on = pins_s2_q.power_save & pins_s2_q.test_mode; // R16 R21
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_mon_q <= 1'b0;
            vco_mon_q <= 1'b0;
        end else begin
            ref_mon_q <= monitor_on & ref_ev; // R21
            vco_mon_q <= monitor_on & vco_ev; // R21
        end
    end

    // pin outputs
    assign cp_drive = cp_drive_q;
    assign cp_drive_oe = cp_oe_q;
    assign modulus_ctrl = modulus_q;
    assign lock_indicator = lock_q;
    assign ref_monitor = ref_mon_q;
    assign vco_monitor = vco_mon_q;
    assign status = '{lock: lock_q, active: active, modulus: modulus_q, cp_busy: cp_oe_q};

    // write channel: address and data captured in either order, response after both
    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ~w_hold_q & ~bvalid_q;
    wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
    wire wr_ctrl = reg_hit(aw_addr_q, OFF_CTRL);
    wire wr_known = wr_ctrl | reg_hit(aw_addr_q, OFF_STATUS) | reg_hit(aw_addr_q, OFF_VCO_RATIO)
                    | reg_hit(aw_addr_q, OFF_REF_RATIO);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ctrl_standby_q <= RST_CTRL_STANDBY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl && w_strb_q[0]) begin
                    ctrl_standby_q <= w_data_q[CTRL_STANDBY_BIT];
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // read decode; ratio and status registers are read-only
    always_comb begin
        rd_data_d = '0;
        rd_resp_d = RESP_OKAY;
        if (reg_hit(s_axi_araddr, OFF_CTRL)) begin
            rd_data_d[CTRL_STANDBY_BIT] = ctrl_standby_q;
        end else if (reg_hit(s_axi_araddr, OFF_STATUS)) begin
            rd_data_d = 32'(status);
        end else if (reg_hit(s_axi_araddr, OFF_VCO_RATIO)) begin
            rd_data_d = 32'(vco_ratio_q);
        end else if (reg_hit(s_axi_araddr, OFF_REF_RATIO)) begin
            rd_data_d = 32'(ref_ratio_q);
        end else begin
            rd_resp_d = RESP_SLVERR;
        end
    end

    // read channel: one read outstanding, answer one cycle after the address
    assign s_axi_arready = ~rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_data_d;
            rresp_q <= rd_resp_d;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // checks on the loop behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wake;
        !active ##1 active;
    endsequence
    sequence s_quiet_mod;
        active && !vco_fall ##1 active;
    endsequence

    shift_in_a: assert property (sclk_rise |=> sr_q[0] == $past(pins_s2_q.serial_data)) // R1
        else $error("shift register missed serial bit");
    ref_latch_a: assert property (strobe_on && frame_sel == SEL_REF |=> // R2
        ref_ratio_q == $past(sr_q[R_LSB+R_W-1:R_LSB]) && $stable(vco_ratio_q))
        else $error("reference latch load wrong");
    vco_latch_a: assert property (strobe_on && frame_sel == SEL_VCO |=> // R19
        vco_ratio_q == $past(sr_q[SR_W-1:A_LSB]) && $stable(ref_ratio_q))
        else $error("vco latch load wrong");
    standby_out_a: assert property (!active |=> !cp_drive_oe && lock_indicator) // R4
        else $error("standby outputs not quiet");
    wake_align_a: assert property (s_wake |-> ref_cnt_q == REF_ZERO && main_cnt_q == vco_ratio_q.main) // R5
        else $error("dividers not aligned at wake");
    modulus_hold_a: assert property (s_quiet_mod |-> $stable(modulus_ctrl)) // R7
        else $error("modulus changed without vco edge");
    pump_sense_a: assert property (cp_drive_oe |-> // R12
        cp_drive == ((pd_q == PD_REF_LEAD) ? $past(pins_s2_q.polarity_select) : !$past(pins_s2_q.polarity_select)))
        else $error("pump polarity wrong");
    lock_drop_a: assert property (active && pd_d != PD_IDLE |=> !lock_indicator) // R15
        else $error("lock held during error");
    lock_gain_a: assert property (active && $rose(lock_indicator) |-> zero_cnt_q == LOCK_COUNT) // R14
        else $error("lock rose early");
    monitor_gate_a: assert property (!monitor_on |=> !ref_monitor && !vco_monitor) // R21
        else $error("monitor active outside test");

endmodule // psd_core

/* File: psd_partner.sv */
// serial loader and dual-modulus prescaler model facing the synthesizer core
`timescale 1ns/1ps
module psd_partner
    import psd_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // modulus request from the core
    input wire logic modulus_ctrl,
    // serial loader link
    output logic serial_clk,
    output logic serial_data,
    output logic latch_strobe,
    // prescaler output
    output logic vco_fb
);
    logic [3:0] pre_cnt_q;
    logic [3:0] pre_len_q;

    // prescaler: 8 aclk per cycle on the small modulus, 9 on the large one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= 4'h0;
            pre_len_q <= 4'h8;
        end else if (pre_cnt_q == pre_len_q - 4'h1) begin
            pre_cnt_q <= 4'h0;
            pre_len_q <= (modulus_ctrl == MOD_SMALL) ? 4'h8 : 4'h9;
        end else begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    // falls on each wrap, in step with the bench reference so equal ratios give zero error
    assign vco_fb = (pre_cnt_q >= 4'h4);

    // link idles with the clock low
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // one 24-bit frame, oldest bit first; leading surplus bits must fall off the top
    task automatic send_frame(input logic [23:0] bits);
        for (int i = 23; i >= 0; i--) begin
            serial_data <= bits[i];
            repeat (10) @(posedge aclk);
            serial_clk <= 1'b1;
            repeat (10) @(posedge aclk);
            serial_clk <= 1'b0;
        end
        repeat (10) @(posedge aclk);
        latch_strobe <= 1'b1;
        repeat (20) @(posedge aclk);
        latch_strobe <= 1'b0;
        serial_data <= ~bits[0];
        repeat (10) @(posedge aclk);
    endtask
endmodule // psd_partner

/* File: psd_core_test.sv */
// self-checking bench for the synthesizer core
`timescale 1ns/1ps
module psd_core_test
    import psd_pkg::*;
;
    localparam int PRE_M = 8;
    localparam int TIMEOUT = 40000;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic serial_clk, serial_data, latch_strobe, vco_fb, ref_osc, power_save, polarity_select, test_mode;
    logic cp_drive, cp_drive_oe, modulus_ctrl, lock_indicator, ref_monitor, vco_monitor, lead_ref;
    logic [2:0] ref_cnt_q;
    logic [11:0] r;
    logic [10:0] n, cn;
    logic [6:0] a, ca;
    int miscompares, tests_run, cycles, oe_cnt, mon_cnt, mark, width, p;

    psd_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clk, .serial_data,
        .latch_strobe, .vco_fb, .ref_osc, .power_save, .polarity_select, .test_mode, .cp_drive, .cp_drive_oe,
        .modulus_ctrl, .lock_indicator, .ref_monitor, .vco_monitor);
    psd_partner far (.aclk, .aresetn, .modulus_ctrl, .serial_clk, .serial_data, .latch_strobe, .vco_fb);

    // 250 mhz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // 8-aclk reference, re-phased to the prescaler wrap in standby
    always @(posedge aclk) begin
        ref_cnt_q <= (!aresetn || (!power_save && far.pre_cnt_q == far.pre_len_q - 4'h1)) ? 3'h0 : ref_cnt_q + 3'h1;
    end
    assign ref_osc = (ref_cnt_q < 3'h4);

    // activity counters and the hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cp_drive_oe === 1'b1) oe_cnt++;
        if (ref_monitor === 1'b1 || vco_monitor === 1'b1) mon_cnt++;
        if (cycles == TIMEOUT) begin
            miscompares++;
            $display("Error at %0t: run did not finish", $time);
            stop_test();
        end
    end

    function automatic int vco_period(int nn, int aa);
        return aa * (PRE_M + 1) + (nn - aa) * PRE_M;
    endfunction

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s response %b expected %b", $time, what, got, exp);
        end
    endtask

    // write: address and data offered together
    task automatic axi_wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d, output logic [1:0] rs);
        bit done;
        done = 0;
        rs = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [31:0] exp, input logic [1:0] er);
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        chk(rd, exp, "read data");
        chk_resp(resp, er, "read");
    endtask

    task automatic chk_ratios(input logic [10:0] nn, input logic [6:0] aa, input logic [11:0] rr);
        rd_chk(OFF_VCO_RATIO, {14'h0, nn, aa}, RESP_OKAY);
        rd_chk(OFF_REF_RATIO, {20'h0, rr}, RESP_OKAY);
    endtask

    // random surplus bits lead each frame
    task automatic load(input logic [10:0] nn, input logic [6:0] aa, input logic [11:0] rr);
        far.send_frame({11'($urandom), rr, SEL_REF});
        far.send_frame({5'($urandom), nn, aa, SEL_VCO});
    endtask

    // cycles between the second and third monitor pulse
    task automatic period(input logic vco, output int pp);
        int seen;
        int t;
        seen = 0;
        t = 0;
        pp = 0;
        while (seen < 3 && t < 3000) begin
            @(posedge aclk);
            t++;
            if (seen == 2) pp++;
            if ((vco ? vco_monitor : ref_monitor) === 1'b1) seen++;
        end
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        power_save = 1'b0;
        polarity_select = 1'b0;
        test_mode = 1'b0;
        void'($urandom(58));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFF_CTRL, 32'h0, RESP_OKAY);
        rd_chk(OFF_STATUS, 32'ha, RESP_OKAY);
        chk_ratios(RST_MAIN, RST_SWALLOW, RST_REF);
        axi_wr(OFF_STATUS, 32'hf, resp);
        chk_resp(resp, RESP_OKAY, "status write");
        rd_chk(OFF_STATUS, 32'ha, RESP_OKAY);
        axi_wr(8'h10, 32'h1, resp);
        chk_resp(resp, RESP_SLVERR, "unmapped write");
        rd_chk(8'h14, 32'h0, RESP_SLVERR);
        // corner ratios first, then random ones; the other divider must keep its ratio
        {cn, ca} = {RST_MAIN, RST_SWALLOW};
        for (int i = 0; i < 6; i++) begin
            if (i == 0) {n, a, r} = {11'h7ff, 7'h7f, 12'hfff};
            else if (i == 1) {n, a, r} = {11'h005, 7'h00, 12'h005};
            else {n, a, r} = {11'(128 + $urandom % 1920), 7'($urandom), 12'(5 + $urandom % 4091)};
            far.send_frame({11'($urandom), r, SEL_REF});
            chk_ratios(cn, ca, r);
            far.send_frame({5'($urandom), n, a, SEL_VCO});
            chk_ratios(n, a, r);
            {cn, ca} = {n, a};
        end
        // equal ratios: wake-up alignment gives zero error and lock after four comparisons
        load(11'h005, 7'h00, 12'h005);
        mark = oe_cnt + mon_cnt;
        power_save <= 1'b1;
        repeat (150) @(posedge aclk);
        chk_bit(lock_indicator, 1'b0, "lock early");
        repeat (100) @(posedge aclk);
        chk_bit(lock_indicator, 1'b1, "lock late");
        chk(32'(oe_cnt + mon_cnt), 32'(mark), "pump or monitor activity");
        // unequal ratios: pulse width and sense for both leads and both polarities
        for (int k = 0; k < 4; k++) begin
            power_save <= 1'b0;
            repeat (6) @(posedge aclk);
            chk_bit(lock_indicator, 1'b1, "standby lock");
            chk_bit(cp_drive_oe, 1'b0, "standby pump");
            polarity_select <= k[0];
            lead_ref = k[1];
            load(lead_ref ? 11'h006 : 11'h004, 7'h00, lead_ref ? 12'h004 : 12'h006);
            power_save <= 1'b1;
            width = 0;
            while (cp_drive_oe !== 1'b1 && width < 1000) begin
                @(posedge aclk);
                width++;
            end
            width = 0;
            while (cp_drive_oe === 1'b1 && width < 100) begin
                if (width == 2) chk_bit(lock_indicator, 1'b0, "lock on error");
                if (width == 2) chk_bit(cp_drive, lead_ref ? k[0] : ~k[0], "pump sense");
                @(posedge aclk);
                width++;
            end
            chk(32'(width), 32'(2 * PRE_M), "pump width");
        end
        // pulse swallow and reference division seen on the monitors
        power_save <= 1'b0;
        load(11'h007, 7'h03, 12'h006);
        test_mode <= 1'b1;
        power_save <= 1'b1;
        period(1'b1, p);
        chk(32'(p), 32'(vco_period(7, 3)), "vco period");
        period(1'b0, p);
        chk(32'(p), 32'(6 * PRE_M), "ref period");
        // software standby through the control register
        axi_wr(OFF_CTRL, 32'h1, resp);
        repeat (6) @(posedge aclk);
        mark = mon_cnt;
        repeat (100) @(posedge aclk);
        chk_bit(lock_indicator, 1'b1, "soft standby lock");
        chk_bit(cp_drive_oe, 1'b0, "soft standby pump");
        chk(32'(mon_cnt), 32'(mark), "soft standby monitors");
        rd_chk(OFF_CTRL, 32'h1, RESP_OKAY);
        stop_test();
    end
endmodule // psd_core_test
